// [design/ref_status_pkg.sv]
// Purpose: Constants shared by the reference status readback bank
// Assumes: Byte-wide register port with 16-bit byte addresses
// Notes:   Offsets are byte addresses of single-byte registers
package ref_status_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [15:0] OFF_UPDATE          = 16'h0005;
  localparam logic [15:0] OFF_REF_PAIR_LOW    = 16'h0d0b;
  localparam logic [15:0] OFF_REF_PAIR_HIGH   = 16'h0d0c;
  localparam logic [15:0] OFF_TUNING_BYTE0    = 16'h0d0d;
  localparam logic [15:0] OFF_TUNING_BYTE1    = 16'h0d0e;
  localparam logic [15:0] OFF_TUNING_BYTE2    = 16'h0d0f;
  localparam logic [15:0] OFF_TUNING_BYTE3    = 16'h0d10;
  localparam logic [15:0] OFF_PHASE_BKT_LOW   = 16'h0d11;
  localparam logic [15:0] OFF_PHASE_BKT_HIGH  = 16'h0d12;
  localparam logic [15:0] OFF_FREQ_BKT_LOW    = 16'h0d13;
  localparam logic [15:0] OFF_FREQ_BKT_HIGH   = 16'h0d14;
  localparam logic [15:0] OFF_NVM_WPROT       = 16'h0e00;
  localparam logic [15:0] OFF_IRQ_STATUS      = 16'h0e80;
  localparam logic [15:0] OFF_IRQ_MASK        = 16'h0e81;

  // Update command value
  localparam logic [7:0] UPDATE_CMD = 8'h01;

  // Nibble layout of one reference input
  localparam int unsigned FLD_SLOW  = 0;
  localparam int unsigned FLD_FAST  = 1;
  localparam int unsigned FLD_FAULT = 2;
  localparam int unsigned FLD_VALID = 3;

  // Write protect bit
  localparam int unsigned FLD_WPROT_EN = 0;

  // Interrupt status bits
  localparam int unsigned IRQ_UPDATE_DONE = 0;
  localparam int unsigned IRQ_REF_CHANGE  = 1;
  localparam int unsigned IRQ_CLK_MISSING = 2;
  localparam int unsigned IRQ_W           = 3;

  // Widths
  localparam int unsigned TUNING_W = 30;
  localparam int unsigned BUCKET_W = 12;
  localparam int unsigned NUM_REF  = 4;

  // Reset values
  localparam logic [7:0]  RST_BYTE  = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;

endpackage : ref_status_pkg

// [design/ref_status_readback_bank.sv]
// Purpose: Readback of reference status, tuning word and lock buckets
// Assumes: Status inputs come from logic on clk; port is a byte bus
// Notes:   Snapshot changes only on the update command
// Operation
// - Valid flag set only while input unfaulted and validation timer expired.
// - Fault flag set whenever the input is not usable.
// - Fast flag set when measured frequency is above profile bound.
// - Slow flag set when measured frequency is below profile bound.
// - Missing clock reported as fast and slow both set.
// - Third and fourth inputs in second byte, fourth in upper nibble.
// - Writing update command to update register refreshes snapshot.
// - Current 30-bit tuning word readable as history registers.
// - Tuning word over four bytes, least significant first.
// - Phase bucket 12 bits, high nibble of second byte reserved.
// - Frequency bucket 12 bits, high nibble of second byte reserved.
// - Memory write protected while control bit 0 is zero.
// - Write protect setting applies immediately on write.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
module ref_status_readback_bank
  import ref_status_pkg::*;
(
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // Register port
  input  wire logic [ADDR_W-1:0]   reg_addr,
  input  wire logic [DATA_W-1:0]   reg_wdata,
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  output logic      [DATA_W-1:0]   reg_rdata,
  // Live reference monitor status, one bit per input
  input  wire logic [NUM_REF-1:0]  ref_unfaulted,
  input  wire logic [NUM_REF-1:0]  ref_timer_expired,
  input  wire logic [NUM_REF-1:0]  ref_freq_high,
  input  wire logic [NUM_REF-1:0]  ref_freq_low,
  input  wire logic [NUM_REF-1:0]  ref_clk_missing,
  // Live loop status
  input  wire logic [TUNING_W-1:0] tuning_word,
  input  wire logic [BUCKET_W-1:0] phase_bucket,
  input  wire logic [BUCKET_W-1:0] freq_bucket,
  // Control and interrupt
  output logic                     nvm_write_en,
  output logic                     irq
);

  logic [7:0]          ref_pair_low_r;
  logic [7:0]          ref_pair_high_r;
  logic [TUNING_W-1:0] tuning_r;
  logic [BUCKET_W-1:0] phase_bkt_r;
  logic [BUCKET_W-1:0] freq_bkt_r;
  logic                wprot_r;
  logic [IRQ_W-1:0]    irq_stat_r;
  logic [IRQ_W-1:0]    irq_mask_r;
  logic [IRQ_W-1:0]    irq_mask_nxt;
  logic [IRQ_W-1:0]    irq_set;
  logic [IRQ_W-1:0]    irq_stat_nxt;
  logic [NUM_REF-1:0]  prev_valid_r;
  logic [15:0]         flags_live;
  logic                update_cmd;
  logic [7:0]          rdata_nxt;

  // Build one status nibble from a reference input's monitor
  function automatic logic [3:0] ref_nibble(
    input logic unfaulted,
    input logic expired,
    input logic high,
    input logic low,
    input logic missing
  );
    logic [3:0] n;
    n = 4'h0;
    n[FLD_VALID] = unfaulted & expired & ~missing;
    n[FLD_FAULT] = ~(unfaulted & expired) | missing;
    n[FLD_FAST]  = high | missing;
    n[FLD_SLOW]  = low  | missing;
    return n;
  endfunction : ref_nibble

  always_comb begin
    flags_live = 16'h0000;
    for (int i = 0; i < NUM_REF; i++) begin
      flags_live[4*i +: 4] = ref_nibble(ref_unfaulted[i],
                                        ref_timer_expired[i],
                                        ref_freq_high[i],
                                        ref_freq_low[i],
                                        ref_clk_missing[i]);
    end
  end

  assign update_cmd = reg_wr && (reg_addr == OFF_UPDATE) &&
                      (reg_wdata == UPDATE_CMD);

  // Snapshot registers; they move only on the update command
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_pair_low_r  <= RST_BYTE;
      ref_pair_high_r <= RST_BYTE;
      tuning_r        <= '0;
      phase_bkt_r     <= '0;
      freq_bkt_r      <= '0;
    end else if (update_cmd) begin
      ref_pair_low_r  <= flags_live[7:0];
      ref_pair_high_r <= flags_live[15:8];
      tuning_r        <= tuning_word;
      phase_bkt_r     <= phase_bucket;
      freq_bkt_r      <= freq_bucket;
    end
  end

  // Write protect is live: no update command needed
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wprot_r <= 1'b0;
    end else if (reg_wr && reg_addr == OFF_NVM_WPROT) begin
      wprot_r <= reg_wdata[FLD_WPROT_EN];
    end
  end

  assign nvm_write_en = wprot_r;

  // Events come from the live flags the snapshot takes at the update, so software sees matching status
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_UPDATE_DONE] = update_cmd;
    for (int i = 0; i < NUM_REF; i++) begin
      if (update_cmd && (flags_live[4*i+FLD_VALID] != prev_valid_r[i])) begin
        irq_set[IRQ_REF_CHANGE] = 1'b1;
      end
      if (update_cmd && flags_live[4*i+FLD_FAST] &&
          flags_live[4*i+FLD_SLOW]) begin
        irq_set[IRQ_CLK_MISSING] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prev_valid_r <= '0;
    end else if (update_cmd) begin
      for (int i = 0; i < NUM_REF; i++) begin
        prev_valid_r[i] <= flags_live[4*i+FLD_VALID];
      end
    end
  end

  // Read clears status, but a set in the same cycle wins
  always_comb begin
    irq_stat_nxt = irq_stat_r;
    if (reg_rd && reg_addr == OFF_IRQ_STATUS) begin
      irq_stat_nxt = '0;
    end
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_stat_r <= RST_IRQ;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // Next mask, so the line follows a mask write without a lag
  always_comb begin
    irq_mask_nxt = irq_mask_r;
    if (reg_wr && reg_addr == OFF_IRQ_MASK) begin
      irq_mask_nxt = reg_wdata[IRQ_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq_mask_r <= RST_IRQ;
    end else begin
      irq_mask_r <= irq_mask_nxt;
    end
  end

  // Registered so the output comes straight from a flip-flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_nxt & irq_mask_nxt);
    end
  end

  // Read mux; unmapped and reserved bits read zero
  always_comb begin
    rdata_nxt = 8'h00;
    unique case (reg_addr)
      OFF_REF_PAIR_LOW:   rdata_nxt = ref_pair_low_r;
      OFF_REF_PAIR_HIGH:  rdata_nxt = ref_pair_high_r;
      OFF_TUNING_BYTE0:   rdata_nxt = tuning_r[7:0];
      OFF_TUNING_BYTE1:   rdata_nxt = tuning_r[15:8];
      OFF_TUNING_BYTE2:   rdata_nxt = tuning_r[23:16];
      OFF_TUNING_BYTE3:   rdata_nxt = {2'h0, tuning_r[29:24]};
      OFF_PHASE_BKT_LOW:  rdata_nxt = phase_bkt_r[7:0];
      OFF_PHASE_BKT_HIGH: rdata_nxt = {4'h0, phase_bkt_r[11:8]};
      OFF_FREQ_BKT_LOW:   rdata_nxt = freq_bkt_r[7:0];
      OFF_FREQ_BKT_HIGH:  rdata_nxt = {4'h0, freq_bkt_r[11:8]};
      OFF_NVM_WPROT:      rdata_nxt = {7'h00, wprot_r};
      OFF_IRQ_STATUS:     rdata_nxt = {5'h00, irq_stat_r};
      OFF_IRQ_MASK:       rdata_nxt = {5'h00, irq_mask_r};
      default:            rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

endmodule : ref_status_readback_bank

// [verification/ref_status_readback_bank_assertions.sv]
// Purpose: Port assertions for the status readback bank
// Assumes: One clock, byte register port, read data one cycle late
// Notes:   Sees only the bank ports; bound below
`timescale 1ns/100ps
module ref_status_readback_bank_checker
  import ref_status_pkg::*;
(
  // Clock and reset
  input wire logic                clk,
  input wire logic                rstn,
  // Register port
  input wire logic [ADDR_W-1:0]   reg_addr,
  input wire logic [DATA_W-1:0]   reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [DATA_W-1:0]   reg_rdata,
  // Live status and control
  input wire logic [NUM_REF-1:0]  ref_unfaulted,
  input wire logic [NUM_REF-1:0]  ref_timer_expired,
  input wire logic [NUM_REF-1:0]  ref_freq_low,
  input wire logic [NUM_REF-1:0]  ref_clk_missing,
  input wire logic                nvm_write_en
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  sequence s_upd;
    reg_wr && reg_addr == OFF_UPDATE && reg_wdata == UPDATE_CMD;
  endsequence
  sequence s_rd(logic [15:0] a);
    reg_rd && reg_addr == a;
  endsequence
  // Inputs are sampled at the update edge, two edges before the data
  chk_snap_flags: assert property (s_upd ##1 s_rd(OFF_REF_PAIR_LOW) |=>
    reg_rdata[0] == $past(ref_freq_low[0] | ref_clk_missing[0], 2) &&
    reg_rdata[7] == $past(ref_unfaulted[1] & ref_timer_expired[1] &
    ~ref_clk_missing[1], 2)) else $error("snapshot flags wrong");
  chk_wp_live: assert property (reg_wr && reg_addr == OFF_NVM_WPROT
    |=> nvm_write_en == $past(reg_wdata[0])) else $error("wp not live");
  chk_wp_hold: assert property (!(reg_wr && reg_addr == OFF_NVM_WPROT)
    |=> $stable(nvm_write_en)) else $error("wp changed alone");
  chk_wp_read: assert property (s_rd(OFF_NVM_WPROT) |=>
    reg_rdata == {7'h00, $past(nvm_write_en)}) else $error("wp read");
  chk_bkt_rsvd: assert property (reg_rd &&
    (reg_addr == OFF_PHASE_BKT_HIGH || reg_addr == OFF_FREQ_BKT_HIGH)
    |=> reg_rdata[7:4] == 4'h0) else $error("bucket reserved bits");
  chk_tw_top: assert property (s_rd(OFF_TUNING_BYTE3) |=>
    reg_rdata[7:6] == 2'b00) else $error("tuning top bits");
  chk_rd_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data without read");
  chk_unmapped: assert property (s_rd(16'h0d0a)
    |=> reg_rdata == 8'h00) else $error("reserved byte not zero");
endmodule : ref_status_readback_bank_checker
bind ref_status_readback_bank ref_status_readback_bank_checker checker_i (
  .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .ref_unfaulted, .ref_timer_expired, .ref_freq_low, .ref_clk_missing,
  .nvm_write_en
);

// [verification/ref_status_readback_bank_tb.sv]
// Purpose: Self-checking bench for the status readback bank
// Assumes: Strobes driven just after a rising edge
// Notes:   Inputs flip after each row's update to prove the snapshot holds
`timescale 1ns/100ps
module ref_status_readback_bank_tb
  import ref_status_pkg::*;
;
  logic        clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0, q;
  logic [15:0] reg_addr = 0;
  logic [7:0]  reg_wdata = 0, reg_rdata, d;
  logic [3:0]  unf = 0, tex = 0, hi = 0, lo = 0, ms = 0;
  logic [29:0] tw = 0;
  logic [11:0] pb = 0, fb = 0;
  logic        nvm_write_en, irq;
  logic [73:0] r;
  logic [7:0]  e [10];
  int          n_mismatch = 0, total_checks = 0;
  // Rows: {unf, tex, hi, lo, ms, tw, pb, fb} and {high, low} flag bytes
  logic [73:0] row [2] = '{{20'hff248, 30'h2a5b3c4d, 12'habc, 12'h123},
                           {20'hde004, 30'h15a4c3b2, 12'h5f0, 12'h00f}};
  logic [15:0] ef [2] = '{16'h79a8, 16'h8744};
  always #10 clk = ~clk;
  ref_status_readback_bank ref_status_readback_bank_i (
    .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .ref_unfaulted(unf), .ref_timer_expired(tex), .ref_freq_high(hi),
    .ref_freq_low(lo), .ref_clk_missing(ms), .tuning_word(tw),
    .phase_bucket(pb), .freq_bucket(fb), .nvm_write_en, .irq
  );
  task automatic chk(string n, logic [7:0] x, logic [7:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, x, g);
    end
  endtask : chk
  // No release here, so a write may be followed by any access at once
  task automatic wr(logic [15:0] a, logic [7:0] w);
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= {a, w, 2'b10};
    @(posedge clk);
  endtask : wr
  task automatic rd(logic [15:0] a);
    {reg_addr, reg_wr, reg_rd} <= {a, 2'b01};
    @(posedge clk);
    {reg_wr, reg_rd} <= 2'b00;
    #1 {d, q} = {reg_rdata, irq};
    @(posedge clk);
  endtask : rd
  task automatic print_verdict;
    if (n_mismatch == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rd(OFF_REF_PAIR_LOW);
    chk("pair_low", 8'h00, d);
    chk("wp_reset", 8'h00, {7'h0, nvm_write_en});
    foreach (row[i]) begin
      {unf, tex, hi, lo, ms, tw, pb, fb} <= row[i];
      wr(OFF_UPDATE, UPDATE_CMD);
      {unf, tex, hi, lo, ms, tw, pb, fb} <= ~row[i];
      r = row[i];
      e = '{ef[i][7:0], ef[i][15:8], r[31:24], r[39:32], r[47:40],
            {2'b00, r[53:48]}, r[19:12], {4'h0, r[23:20]}, r[7:0],
            {4'h0, r[11:8]}};
      for (int k = 0; k < 10; k++) begin
        rd(OFF_REF_PAIR_LOW + 16'(k));
        chk("status", e[k], d);
      end
    end
    wr(OFF_UPDATE, 8'h02);
    wr(OFF_REF_PAIR_HIGH, 8'hff);
    rd(OFF_REF_PAIR_HIGH);
    chk("stale", ef[1][15:8], d);
    wr(OFF_NVM_WPROT, 8'hff);
    rd(OFF_NVM_WPROT);
    chk("wp_on", 8'h01, d);
    chk("wp_pin", 8'h01, {7'h0, nvm_write_en});
    wr(OFF_NVM_WPROT, 8'h00);
    rd(OFF_NVM_WPROT);
    chk("wp_off", 8'h00, d);
    // Mask still zero: status sticks but the line stays low
    rd(OFF_IRQ_STATUS);
    chk("irq_st", 8'h07, d);
    chk("irq_masked", 8'h00, {7'h0, q});
    rd(OFF_IRQ_STATUS);
    chk("irq_clr", 8'h00, d);
    wr(OFF_IRQ_MASK, 8'h01);
    wr(OFF_UPDATE, UPDATE_CMD);
    // A status read clears the line at its own edge, so look via the mask
    rd(OFF_IRQ_MASK);
    chk("irq_mask", 8'h01, d);
    chk("irq_on", 8'h01, {7'h0, q});
    rd(OFF_IRQ_STATUS);
    chk("irq_st2", 8'h07, d);
    chk("irq_clr2", 8'h00, {7'h0, q});
    rd(16'h0d0a);
    chk("unmapped", 8'h00, d);
    chk("irq_off", 8'h00, {7'h0, q});
    print_verdict();
  end
endmodule : ref_status_readback_bank_tb
